// ### rtl/status_pkg.sv
// Shared constants and carriers for the status and event reporting block.
// Assumes a single 50 MHz clock domain.
package status_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int W = 8;
    // Event status bit positions
    localparam int POWER_ON_BIT = 7;
    localparam int USER_REQUEST_BIT = 6;
    localparam int COMMAND_ERROR_BIT = 5;
    localparam int EXECUTION_ERROR_BIT = 4;
    localparam int DEVICE_ERROR_BIT = 3;
    localparam int QUERY_ERROR_BIT = 2;
    localparam int REQUEST_CONTROL_BIT = 1;
    localparam int OPERATION_COMPLETE_BIT = 0;
    // Status byte bit positions
    localparam int REQUEST_SERVICE_BIT = 6;
    localparam int EVENT_SUMMARY_BIT = 5;
    localparam int MESSAGE_AVAILABLE_BIT = 4;
    // Bits that may ever be set in the event status register
    localparam logic [7:0] EVENT_USED_MASK = 8'hBD;
    // Status byte bits that may feed a service request
    localparam logic [7:0] STATUS_USED_MASK = 8'h30;
    // Reset values
    localparam logic [7:0] DEVICE_EVENT_ENABLE_RESET = 8'hFF;
    localparam logic [7:0] EVENT_SUMMARY_ENABLE_RESET = 8'h00;
    localparam logic [7:0] SERVICE_REQUEST_ENABLE_RESET = 8'h00;

    // Event sources, one-cycle pulses
    typedef struct packed {
        logic command_error;
        logic execution_error;
        logic device_error;
        logic query_error;
        logic operation_complete;
    } event_in_t;

    // Mask write strobes with their data
    typedef struct packed {
        logic device_event_enable_command;
        logic event_summary_enable_command;
        logic service_request_enable_command;
        logic [7:0] data;
    } mask_write_t;

    // Mask readback
    typedef struct packed {
        logic [7:0] device_event_enable_mask;
        logic [7:0] event_summary_enable_mask;
        logic [7:0] service_request_enable_mask;
    } mask_read_t;
endpackage : status_pkg

// ### rtl/event_recorder.sv
// Sticky event status register with per-bit recording enable.
// Assumes event pulses are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module event_recorder
    import status_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Events
    input wire logic [7:0] event_raw,
    input wire logic [7:0] device_event_enable_mask,
    input wire logic read_clear,
    // State
    output logic [7:0] standard_event_status,
    output logic [7:0] recorded
);
    logic [7:0] status_reg;
    logic [7:0] status_next;

    always_comb begin
        recorded = event_raw & device_event_enable_mask & EVENT_USED_MASK;
        status_next = status_reg;
        if (read_clear) begin
            status_next = 8'h00;
        end
        status_next = status_next | recorded;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= 8'h00;
        end else begin
            status_reg <= status_next;
        end
    end

    assign standard_event_status = status_reg;
endmodule : event_recorder
`default_nettype wire

// ### rtl/event_status_reporting.sv
// Status byte, enable masks and service request generation for a bus instrument.
// Assumes one clock, power-on reset on resetn, and commands decoded upstream.
//
// Contract
// - Set power-on flag, bit 7, when power comes on.
// - Never set user-request flag, bit 6.
// - Set command-error flag, bit 5, on parser error.
// - Set execution-error flag, bit 4, on bad argument or unmet conditions.
// - Set device-specific-error flag, bit 3, on internal error.
// - Set query-error flag, bit 2, on empty read or discarded output.
// - Never set request-control flag, bit 1.
// - Set operation-complete flag, bit 0, when pending operations finish.
// - Each mask bit gates the same-position status bit.
// - Record and queue an event only if device event enable bit set.
// - Event summary set only by an enabled set event status bit.
// - Cleared summary enable bit keeps its event from the summary.
// - Service request enable mask drives status byte bit 6.
// - Drive the service request line low while requesting service.
// - Serial poll returns status byte with request-service bit when pending.
// - Device event enable mask writable and readable back.
// - Event summary enable mask writable and readable back.
// - Service request enable mask writable and readable back.
// - Request-service bit clears when the serial poll ends.
// - Status byte bits 0 to 3 and 7 read zero.
// - Reading the event status register clears it.
`timescale 1ns/10ps
`default_nettype none
module event_status_reporting
    import status_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Event sources
    input wire event_in_t events,
    input wire logic message_available,
    // Mask commands
    input wire mask_write_t mask_write,
    output logic [23:0] mask_readback,
    // Event status query
    input wire logic event_status_read,
    output logic [7:0] event_status_data,
    // Serial poll
    input wire logic serial_poll_active,
    output logic [7:0] status_byte,
    output logic [7:0] serial_poll_byte,
    // Event queue push
    output logic [7:0] event_push,
    // Bus service request, open drain
    output logic srq_o,
    output logic srq_oe
);
    logic [7:0] device_event_enable_mask_reg;
    logic [7:0] device_event_enable_mask_next;
    logic [7:0] event_summary_enable_mask_reg;
    logic [7:0] event_summary_enable_mask_next;
    logic [7:0] service_request_enable_mask_reg;
    logic [7:0] service_request_enable_mask_next;
    logic power_pending_reg;
    logic power_pending_next;
    logic request_service_reg;
    logic request_service_next;
    logic poll_hold_reg;
    logic poll_hold_next;
    logic poll_reg;
    logic poll_next;
    logic [7:0] push_reg;
    logic [7:0] push_next;
    logic [7:0] data_reg;
    logic [7:0] data_next;
    logic [7:0] poll_byte_reg;
    logic [7:0] poll_byte_next;
    logic [7:0] event_raw;
    logic [7:0] recorded;
    logic [7:0] standard_event_status;
    logic [7:0] summary_byte;
    logic master_summary;
    mask_read_t readback;

    // Any enabled set bit in the masked pair
    function automatic logic masked_any(input logic [7:0] bits, input logic [7:0] mask);
        masked_any = |(bits & mask);
    endfunction : masked_any

    always_comb begin
        event_raw = 8'h00;
        event_raw[POWER_ON_BIT] = power_pending_reg;
        event_raw[COMMAND_ERROR_BIT] = events.command_error;
        event_raw[EXECUTION_ERROR_BIT] = events.execution_error;
        event_raw[DEVICE_ERROR_BIT] = events.device_error;
        event_raw[QUERY_ERROR_BIT] = events.query_error;
        event_raw[OPERATION_COMPLETE_BIT] = events.operation_complete;
    end

    event_recorder recorder (
        .clk(clk),
        .resetn(resetn),
        .event_raw(event_raw),
        .device_event_enable_mask(device_event_enable_mask_reg),
        .read_clear(event_status_read),
        .standard_event_status(standard_event_status),
        .recorded(recorded)
    );

    // Status byte without the request bit
    always_comb begin
        summary_byte = 8'h00;
        summary_byte[EVENT_SUMMARY_BIT] =
            masked_any(standard_event_status, event_summary_enable_mask_reg);
        summary_byte[MESSAGE_AVAILABLE_BIT] = message_available;
        master_summary = masked_any(summary_byte,
            service_request_enable_mask_reg & STATUS_USED_MASK);
    end

    // Mask registers
    always_comb begin
        device_event_enable_mask_next = device_event_enable_mask_reg;
        event_summary_enable_mask_next = event_summary_enable_mask_reg;
        service_request_enable_mask_next = service_request_enable_mask_reg;
        if (mask_write.device_event_enable_command) begin
            device_event_enable_mask_next = mask_write.data;
        end
        if (mask_write.event_summary_enable_command) begin
            event_summary_enable_mask_next = mask_write.data;
        end
        if (mask_write.service_request_enable_command) begin
            service_request_enable_mask_next = mask_write.data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            device_event_enable_mask_reg <= DEVICE_EVENT_ENABLE_RESET;
            event_summary_enable_mask_reg <= EVENT_SUMMARY_ENABLE_RESET;
            service_request_enable_mask_reg <= SERVICE_REQUEST_ENABLE_RESET;
        end else begin
            device_event_enable_mask_reg <= device_event_enable_mask_next;
            event_summary_enable_mask_reg <= event_summary_enable_mask_next;
            service_request_enable_mask_reg <= service_request_enable_mask_next;
        end
    end

    // Power-on event, request service and poll state
    always_comb begin
        power_pending_next = 1'b0;
        poll_next = serial_poll_active;
        request_service_next = request_service_reg;
        poll_hold_next = poll_hold_reg;
        // A summary left standing after a poll must drop before it requests again
        if (!master_summary) begin
            poll_hold_next = 1'b0;
        end
        if (master_summary && !request_service_reg && !serial_poll_active
            && !poll_hold_reg) begin
            request_service_next = 1'b1;
        end
        if (!master_summary && !serial_poll_active) begin
            request_service_next = 1'b0;
        end
        if (poll_reg && !serial_poll_active) begin
            request_service_next = 1'b0;
            poll_hold_next = master_summary;
        end
        push_next = recorded;
        data_next = event_status_read ? standard_event_status : data_reg;
        poll_byte_next = summary_byte;
        poll_byte_next[REQUEST_SERVICE_BIT] = request_service_reg;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            power_pending_reg <= 1'b1;
            request_service_reg <= 1'b0;
            poll_hold_reg <= 1'b0;
            poll_reg <= 1'b0;
            push_reg <= 8'h00;
            data_reg <= 8'h00;
            poll_byte_reg <= 8'h00;
        end else begin
            power_pending_reg <= power_pending_next;
            request_service_reg <= request_service_next;
            poll_hold_reg <= poll_hold_next;
            poll_reg <= poll_next;
            push_reg <= push_next;
            data_reg <= data_next;
            poll_byte_reg <= poll_byte_next;
        end
    end

    always_comb begin
        readback.device_event_enable_mask = device_event_enable_mask_reg;
        readback.event_summary_enable_mask = event_summary_enable_mask_reg;
        readback.service_request_enable_mask = service_request_enable_mask_reg;
        status_byte = summary_byte;
        status_byte[REQUEST_SERVICE_BIT] = master_summary;
    end

    assign mask_readback = readback;
    assign event_status_data = data_reg;
    assign serial_poll_byte = poll_byte_reg;
    assign event_push = push_reg;
    assign srq_o = 1'b0;
    assign srq_oe = request_service_reg;
endmodule : event_status_reporting
`default_nettype wire

// ### verification/esr_monitor.sv
// Checker for the status reporting block, watching its ports only.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module esr_monitor
    import status_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Watched ports
    input wire event_in_t events,
    input wire mask_write_t mask_write,
    input wire logic [23:0] mask_readback,
    input wire logic event_status_read,
    input wire logic serial_poll_active,
    input wire logic [7:0] status_byte,
    input wire logic [7:0] serial_poll_byte,
    input wire logic [7:0] event_push,
    input wire logic srq_o,
    input wire logic srq_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_unused_zero: assert property ((status_byte & 8'h8F) == 8'h00)
        else $error("status byte unused bit set");
    chk_push_reserved: assert property ((event_push & 8'h42) == 8'h00)
        else $error("unused event pushed");
    chk_cmd_gated: assert property (
        events.command_error && mask_readback[21] |=> event_push[5])
        else $error("enabled command error not pushed");
    chk_push_cause: assert property (
        event_push[4] |-> $past(events.execution_error && mask_readback[20]))
        else $error("execution error pushed without cause");
    chk_master_sum: assert property (
        status_byte[6] == |(status_byte[5:4] & mask_readback[5:4]))
        else $error("master summary wrong");
    chk_srq_drive: assert property (
        $rose(status_byte[6]) && !serial_poll_active && !$past(serial_poll_active)
        |=> srq_oe && !srq_o)
        else $error("service request not driven low");
    chk_srq_release: assert property (
        !status_byte[6] && !serial_poll_active |=> !srq_oe)
        else $error("service request line held without cause");
    chk_poll_clear: assert property ($fell(serial_poll_active) |=> !srq_oe)
        else $error("request service kept after poll");
    chk_poll_rqs: assert property (
        srq_oe && !serial_poll_active |=> serial_poll_byte[6])
        else $error("poll byte lacks request service");
    chk_read_clear: assert property (
        event_status_read && events == 5'h00 |=> !status_byte[5])
        else $error("summary survives event status read");
    chk_sticky_sum: assert property (
        status_byte[5] && !event_status_read && !mask_write.event_summary_enable_command
        |=> status_byte[5])
        else $error("summary dropped without read");
    chk_sre_load: assert property (
        mask_write.service_request_enable_command
        |=> mask_readback[7:0] == $past(mask_write.data))
        else $error("service request mask not loaded");
    chk_power_on: assert property ($rose(resetn) |-> ##1 event_push[7])
        else $error("power-on event missing");
endmodule : esr_monitor

bind event_status_reporting esr_monitor mon_u (.clk, .resetn, .events, .mask_write,
    .mask_readback, .event_status_read, .serial_poll_active, .status_byte,
    .serial_poll_byte, .event_push, .srq_o, .srq_oe);
`default_nettype wire

// ### verification/bus_controller_model.sv
// Bus controller model: serial polls once per service request.
// Assumes the request line is open drain with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module bus_controller_model (
    // Clock
    input wire logic clk,
    // Device side
    input wire logic srq_o,
    input wire logic srq_oe,
    input wire logic [7:0] serial_poll_byte,
    output logic serial_poll_active,
    // Poll result
    output logic [7:0] polled_byte,
    output logic poll_done
);
    logic srq_line;
    assign srq_line = srq_oe ? srq_o : 1'b1;
    initial begin
        serial_poll_active = 1'b0;
        polled_byte = 8'h00;
        poll_done = 1'b0;
        forever begin
            @(negedge clk);
            poll_done = 1'b0;
            if (srq_line === 1'b0) begin
                serial_poll_active = 1'b1;
                repeat (2) @(negedge clk);
                polled_byte = serial_poll_byte;
                serial_poll_active = 1'b0;
                poll_done = 1'b1;
                @(negedge clk);
                poll_done = 1'b0;
                wait (srq_line !== 1'b0);
            end
        end
    end
endmodule : bus_controller_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the status reporting block.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import status_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    event_in_t events = '0;
    logic message_available = 1'b0;
    mask_write_t mask_write = '0;
    logic event_status_read = 1'b0;
    logic serial_poll_active, poll_done, srq_o, srq_oe;
    logic rd_d = 1'b0;
    logic [23:0] mask_readback;
    logic [7:0] event_status_data, status_byte, serial_poll_byte, event_push, polled_byte, m;
    logic [7:0] esr_q[$];
    logic [7:0] poll_q[$];
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int bits[5] = '{5, 4, 3, 2, 0};

    always #10 clk = ~clk;

    event_status_reporting dut_u (.clk, .resetn, .events, .message_available, .mask_write,
        .mask_readback, .event_status_read, .event_status_data, .serial_poll_active,
        .status_byte, .serial_poll_byte, .event_push, .srq_o, .srq_oe);
    bus_controller_model host_u (.clk, .srq_o, .srq_oe, .serial_poll_byte,
        .serial_poll_active, .polled_byte, .poll_done);

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic write_mask(input int which, input logic [7:0] d);
        @(negedge clk);
        mask_write = {3'(3'b100 >> which), d};
        @(negedge clk);
        mask_write = '0;
    endtask : write_mask

    task automatic fire(input logic [4:0] e);
        @(negedge clk);
        events = e;
        @(negedge clk);
        events = '0;
    endtask : fire

    task automatic read_esr(input logic [7:0] exp);
        @(negedge clk);
        event_status_read = 1'b1;
        esr_q.push_back(exp);
        @(negedge clk);
        event_status_read = 1'b0;
    endtask : read_esr

    // Result watchers take the oldest note
    always @(posedge clk) begin
        rd_d <= event_status_read;
        cycles <= cycles + 1;
        if (poll_done === 1'b1) check("poll byte", 24'(polled_byte), 24'(poll_q.pop_front()));
        if (cycles == 5000) begin
            fail_count++;
            final_report();
        end
    end
    always @(negedge clk) begin
        if (rd_d) check("event status", 24'(event_status_data), 24'(esr_q.pop_front()));
    end

    initial begin
        void'($urandom(12047));
        repeat (10) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        check("mask reset", mask_readback, 24'hFF0000);
        read_esr(8'h80);
        read_esr(8'h00);
        for (int k = 0; k < 10; k++) begin
            m = 8'($urandom);
            m[bits[k % 5]] = (k < 5);
            write_mask(0, m);
            fire(5'(5'h10 >> (k % 5)));
            repeat (3) @(negedge clk);
            read_esr((k < 5) ? 8'(8'h01 << bits[k % 5]) : 8'h00);
        end
        write_mask(0, 8'hFF);
        for (int j = 0; j < 4; j++) begin
            m = (j == 0) ? 8'h42 : 8'($urandom);
            fire(5'h1F);
            write_mask(1, m);
            check("summary bit", 24'(status_byte[5]), 24'(|(m & 8'h3D)));
            read_esr(8'h3D);
        end
        for (int w = 0; w < 3; w++) begin
            m = 8'($urandom);
            if (w == 2) m[6] = 1'b0;
            write_mask(w, m);
            check("mask readback", 24'(mask_readback[23 - 8 * w -: 8]), 24'(m));
        end
        write_mask(0, 8'hFF);
        write_mask(1, 8'hFF);
        for (int j = 0; j < 2; j++) begin
            write_mask(2, j ? 8'h10 : 8'h20);
            poll_q.push_back(j ? 8'h50 : 8'h60);
            if (j == 0) fire(5'h10);
            else message_available = 1'b1;
            repeat (8) @(negedge clk);
            if (j == 0) read_esr(8'h20);
            message_available = 1'b0;
            repeat (4) @(negedge clk);
            check("request line", 24'(srq_oe), 24'h0);
        end
        check("polls left", 24'(poll_q.size()), 24'h0);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
